// File: hw/alm_pkg.sv
// Constants, opcode set and flag layout for the 8-bit arithmetic, logic
// and multiply datapath. Assumes one decoder issuing at most one op a cycle.
// How it works
// [RULE_01] Add with carry sums both sources plus carry into destination.
// [RULE_02] Word add adds a small constant to a register pair, written back.
// [RULE_03] Word subtract removes a small constant from a register pair.
// [RULE_04] Constant subtract takes the instruction constant from destination.
// [RULE_05] Constant subtract with carry also removes the carry flag.
// [RULE_06] Bit set forces to one every destination bit set in the mask.
// [RULE_07] Bit clear ANDs destination with all-ones minus the mask.
// [RULE_08] Test reports zero and negative of a register through flags only.
// [RULE_09] Complement replaces destination with all-ones minus its value.
// [RULE_10] Integer multiplies put the 16-bit product into R1 high, R0 low.
// [RULE_11] Fractional multiplies shift the product left one place first.
// [RULE_12] Mixed fractional multiply treats one operand signed, one unsigned.
// [RULE_13] Result and flags are written in the same op, seen by the next.
package alm_pkg;

    localparam int ALM_DW = 8;
    localparam int ALM_WW = 16;
    localparam int ALM_KW = 6;
    localparam int ALM_RW = 5;
    localparam int ALM_OPW = 5;
    localparam int ALM_FW = 6;
    localparam int ALM_NIB = 4;
    localparam int ALM_MSB = 7;
    localparam int ALM_WMSB = 15;

    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;

    localparam logic [ALM_FW-1:0] ALM_FLAGS_RST = 6'h00;
    localparam logic [ALM_DW-1:0] ALM_ALL_ONES = 8'hFF;
    localparam logic [ALM_RW-1:0] ALM_PROD_IDX = 5'h00;

    typedef enum logic [ALM_OPW-1:0] {
        add_op = 5'b00000,
        add_carry_op = 5'b00001,
        word_add_immediate_op = 5'b00010,
        sub_op = 5'b00011,
        sub_constant_op = 5'b00100,
        sub_carry_op = 5'b00101,
        sub_constant_carry_op = 5'b00110,
        word_sub_immediate_op = 5'b00111,
        and_op = 5'b01000,
        or_op = 5'b01001,
        bit_set_mask_op = 5'b01010,
        bit_clear_mask_op = 5'b01011,
        ones_complement_op = 5'b01100,
        zero_minus_test_op = 5'b01101,
        unsigned_product_op = 5'b01110,
        signed_product_op = 5'b01111,
        signed_unsigned_product_op = 5'b10000,
        fractional_product_op = 5'b10001,
        fractional_signed_op = 5'b10010,
        mixed_sign_fractional_op = 5'b10011
    } alm_op_e;

endpackage

// File: hw/alm_unit.sv
// Arithmetic, logic and multiply datapath with its own status flags.
// Assumes the decoder presents operands and the op in the issue cycle and
// the register file takes the registered write one edge later.
`timescale 1ns/1ps

module alm_unit
    import alm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic op_valid,
    input wire logic [ALM_OPW-1:0] op_code,
    input wire logic [ALM_RW-1:0] dst_idx,
    input wire logic [ALM_DW-1:0] dst_val,
    input wire logic [ALM_DW-1:0] dst_hi_val,
    input wire logic [ALM_DW-1:0] src_val,
    input wire logic [ALM_DW-1:0] imm_k,
    output logic res_valid,
    output logic wr_byte,
    output logic wr_pair,
    output logic wr_prod,
    output logic [ALM_RW-1:0] wr_idx,
    output logic [ALM_WW-1:0] wr_data,
    output logic [ALM_FW-1:0] flags
);

    wire alm_op_e op = alm_op_e'(op_code);
    wire issue = clk_en && op_valid;

    // Byte adder shared by all byte add and subtract forms; the word forms use the word unit.
    wire sub_sel = op inside {sub_op, sub_constant_op, sub_carry_op,
                              sub_constant_carry_op};
    wire use_carry = op inside {add_carry_op, sub_carry_op,
                                sub_constant_carry_op};
    wire imm_sel = op inside {sub_constant_op, sub_constant_carry_op};
    wire [ALM_DW-1:0] opnd_b = imm_sel ? imm_k : src_val;
    wire cin = use_carry && flags[FLG_C];
    wire [ALM_DW:0] a_ext = {1'b0, dst_val};
    wire [ALM_DW:0] b_ext = {1'b0, opnd_b};
    wire [ALM_DW:0] c_ext = {{ALM_DW{1'b0}}, cin};
    wire [ALM_NIB:0] an_ext = {1'b0, dst_val[ALM_NIB-1:0]};
    wire [ALM_NIB:0] bn_ext = {1'b0, opnd_b[ALM_NIB-1:0]};
    wire [ALM_NIB:0] cn_ext = {{ALM_NIB{1'b0}}, cin};
    wire [ALM_DW:0] byte_sum = sub_sel ? a_ext - b_ext - c_ext
                                       : a_ext + b_ext + c_ext;
    wire [ALM_NIB:0] nib_sum = sub_sel ? an_ext - bn_ext - cn_ext
                                       : an_ext + bn_ext + cn_ext;
    wire [ALM_DW-1:0] byte_res = byte_sum[ALM_DW-1:0];
    wire byte_ovf = (sub_sel ^ (dst_val[ALM_MSB] == opnd_b[ALM_MSB]))
                    && (byte_res[ALM_MSB] != dst_val[ALM_MSB]);
    wire byte_zero = (byte_res == '0);
    // A chained subtract can only keep zero if the lower byte was zero too.
    wire sub_chain = sub_sel && use_carry;
    wire byte_z = sub_chain ? (byte_zero && flags[FLG_Z]) : byte_zero;

    // Word unit on a register pair; the constant is zero extended.
    wire word_sub = (op == word_sub_immediate_op);
    wire [ALM_WW-1:0] pair_val = {dst_hi_val, dst_val};
    wire [ALM_WW-1:0] k_word = {{(ALM_WW-ALM_KW){1'b0}}, imm_k[ALM_KW-1:0]};
    wire [ALM_WW:0] pw_ext = {1'b0, pair_val};
    wire [ALM_WW:0] kw_ext = {1'b0, k_word};
    wire [ALM_WW:0] word_sum = word_sub ? pw_ext - kw_ext : pw_ext + kw_ext;
    wire [ALM_WW-1:0] word_res = word_sum[ALM_WW-1:0];
    wire word_ovf = (pair_val[ALM_WMSB] == word_sub)
                    && (word_res[ALM_WMSB] != pair_val[ALM_WMSB]);

    // Multiplier: nine-bit signed operands cover every sign mix at once.
    wire a_signed = op inside {signed_product_op, signed_unsigned_product_op,
                               fractional_signed_op,
                               mixed_sign_fractional_op};
    wire b_signed = op inside {signed_product_op, fractional_signed_op};
    wire frac = op inside {fractional_product_op, fractional_signed_op,
                           mixed_sign_fractional_op};
    wire signed [ALM_DW:0] mul_a = {a_signed & dst_val[ALM_MSB], dst_val};
    wire signed [ALM_DW:0] mul_b = {b_signed & src_val[ALM_MSB], src_val};
    wire signed [2*ALM_DW+1:0] mul_full = mul_a * mul_b; // [RULE_12]
    wire [ALM_WW-1:0] prod = mul_full[ALM_WW-1:0];
    wire [ALM_WW-1:0] prod_out = frac ? {prod[ALM_WW-2:0], 1'b0} // [RULE_11]
                                      : prod;

    // Logic results.
    wire [ALM_DW-1:0] set_res = dst_val | imm_k;
    wire [ALM_DW-1:0] clr_res = dst_val & (ALM_ALL_ONES - imm_k);
    wire [ALM_DW-1:0] com_res = ALM_ALL_ONES - dst_val;

    logic [ALM_DW-1:0] lres;
    logic [ALM_WW-1:0] next_data;
    logic [ALM_FW-1:0] next_flags;
    logic next_byte;
    logic next_pair;
    logic next_prod;
    logic op_legal;

    always_comb begin
        lres = '0;
        next_data = wr_data;
        next_flags = flags;
        next_byte = 1'b0;
        next_pair = 1'b0;
        next_prod = 1'b0;
        op_legal = 1'b1;
        unique case (op)
            add_op, add_carry_op, sub_op, sub_constant_op, sub_carry_op,
            sub_constant_carry_op: begin
                // [RULE_01] [RULE_04] [RULE_05]
                next_data = {{ALM_DW{1'b0}}, byte_res};
                next_byte = 1'b1;
                next_flags[FLG_C] = byte_sum[ALM_DW];
                next_flags[FLG_H] = nib_sum[ALM_NIB];
                next_flags[FLG_V] = byte_ovf;
                next_flags[FLG_N] = byte_res[ALM_MSB];
                next_flags[FLG_Z] = byte_z;
                next_flags[FLG_S] = byte_res[ALM_MSB] ^ byte_ovf;
            end
            word_add_immediate_op, word_sub_immediate_op: begin
                // [RULE_02] [RULE_03]
                next_data = word_res;
                next_pair = 1'b1;
                next_flags[FLG_C] = word_sum[ALM_WW];
                next_flags[FLG_V] = word_ovf;
                next_flags[FLG_N] = word_res[ALM_WMSB];
                next_flags[FLG_Z] = (word_res == '0);
                next_flags[FLG_S] = word_res[ALM_WMSB] ^ word_ovf;
            end
            and_op, or_op, bit_set_mask_op, bit_clear_mask_op,
            ones_complement_op, zero_minus_test_op: begin
                if (op == and_op) begin
                    lres = dst_val & src_val;
                end else if (op == or_op) begin
                    lres = dst_val | src_val;
                end else if (op == bit_set_mask_op) begin
                    lres = set_res; // [RULE_06]
                end else if (op == bit_clear_mask_op) begin
                    lres = clr_res; // [RULE_07]
                end else if (op == ones_complement_op) begin
                    lres = com_res; // [RULE_09]
                end else begin
                    lres = dst_val; // [RULE_08]
                end
                next_data = {{ALM_DW{1'b0}}, lres};
                // The test op only reports; the register is left alone.
                next_byte = (op != zero_minus_test_op); // [RULE_08]
                next_flags[FLG_V] = 1'b0;
                next_flags[FLG_N] = lres[ALM_MSB];
                next_flags[FLG_Z] = (lres == '0);
                next_flags[FLG_S] = lres[ALM_MSB];
                if (op == ones_complement_op) begin
                    next_flags[FLG_C] = 1'b1;
                end
            end
            unsigned_product_op, signed_product_op,
            signed_unsigned_product_op, fractional_product_op,
            fractional_signed_op, mixed_sign_fractional_op: begin
                next_data = prod_out; // [RULE_10]
                next_prod = 1'b1;
                // Carry is the product sign bit before the fractional shift.
                next_flags[FLG_C] = prod[ALM_WMSB];
                next_flags[FLG_Z] = (prod_out == '0);
            end
            default: begin
                op_legal = 1'b0;
            end
        endcase
    end

    wire take = op_valid && op_legal;
    wire [ALM_RW-1:0] next_idx = next_prod ? ALM_PROD_IDX : dst_idx;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            res_valid <= 1'b0;
            wr_byte <= 1'b0;
            wr_pair <= 1'b0;
            wr_prod <= 1'b0;
            wr_idx <= '0;
            wr_data <= '0;
            flags <= ALM_FLAGS_RST;
        end else if (clk_en) begin
            res_valid <= take; // [RULE_13]
            wr_byte <= take && next_byte;
            wr_pair <= take && next_pair;
            wr_prod <= take && next_prod; // [RULE_10]
            if (take) begin
                wr_idx <= next_idx;
                wr_data <= next_data;
                flags <= next_flags; // [RULE_13]
            end
        end
    end

    // Reference model helpers for the checks below.
    wire signed [ALM_WW-1:0] chk_sa = {{ALM_DW{dst_val[ALM_MSB]}}, dst_val};
    wire signed [ALM_WW-1:0] chk_ub = {{ALM_DW{1'b0}}, src_val};
    wire [ALM_WW-1:0] chk_mixed = (chk_sa * chk_ub) << 1;
    wire [ALM_WW-1:0] chk_uprod = {{ALM_DW{1'b0}}, dst_val}
                                  * {{ALM_DW{1'b0}}, src_val};
    // Last legal opcode; every code above it is refused.
    localparam logic [ALM_OPW-1:0] ALM_OP_LAST = mixed_sign_fractional_op;
    wire [ALM_WW-1:0] chk_pair_add = pair_val + k_word;
    wire [ALM_WW-1:0] chk_pair_sub = pair_val - k_word;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_carry_add_sum: assert property ( // [RULE_01]
        issue && op == add_carry_op |=> wr_byte && wr_data[ALM_DW-1:0] ==
        ALM_DW'($past(dst_val) + $past(src_val) + $past(flags[FLG_C])))
        else $error("add with carry result wrong");

    a_word_add_pair: assert property ( // [RULE_02]
        issue && op == word_add_immediate_op |=> wr_pair &&
        wr_data == $past(chk_pair_add) && wr_idx == $past(dst_idx))
        else $error("word add result wrong");

    a_word_sub_pair: assert property ( // [RULE_03]
        issue && op == word_sub_immediate_op |=> wr_pair &&
        wr_data == $past(chk_pair_sub) &&
        flags[FLG_C] == ($past(k_word) > $past(pair_val)))
        else $error("word subtract result wrong");

    a_const_sub_val: assert property ( // [RULE_04]
        issue && op == sub_constant_op |=> wr_byte &&
        wr_data[ALM_DW-1:0] == ALM_DW'($past(dst_val) - $past(imm_k)))
        else $error("constant subtract result wrong");

    a_const_sbc_val: assert property ( // [RULE_05]
        issue && op == sub_constant_carry_op |=> wr_data[ALM_DW-1:0] ==
        ALM_DW'($past(dst_val) - $past(imm_k) - $past(flags[FLG_C])))
        else $error("constant subtract with carry wrong");

    a_mask_set_bits: assert property ( // [RULE_06]
        issue && op == bit_set_mask_op |=> wr_data[ALM_DW-1:0] ==
        ($past(dst_val) | $past(imm_k)))
        else $error("bit set result wrong");

    a_mask_clear_bits: assert property ( // [RULE_07]
        issue && op == bit_clear_mask_op |=>
        (wr_data[ALM_DW-1:0] & $past(imm_k)) == '0 &&
        (wr_data[ALM_DW-1:0] | $past(imm_k)) ==
        ($past(dst_val) | $past(imm_k)))
        else $error("bit clear result wrong");

    a_test_flags_only: assert property ( // [RULE_08]
        issue && op == zero_minus_test_op |=> !wr_byte &&
        flags[FLG_Z] == ($past(dst_val) == '0) &&
        flags[FLG_N] == $past(dst_val[ALM_MSB]))
        else $error("test op flags wrong");

    a_complement_inv: assert property ( // [RULE_09]
        issue && op == ones_complement_op |=>
        wr_data[ALM_DW-1:0] == ~$past(dst_val) && flags[FLG_C])
        else $error("complement result wrong");

    a_product_r1r0: assert property ( // [RULE_10]
        issue && op == unsigned_product_op |=> wr_prod &&
        wr_idx == ALM_PROD_IDX && wr_data == $past(chk_uprod))
        else $error("product not in R1:R0");

    a_frac_shifted: assert property ( // [RULE_11]
        issue && op == fractional_product_op |=>
        wr_data == ALM_WW'($past(chk_uprod) << 1))
        else $error("fractional product not shifted");

    a_mixed_sign_prod: assert property ( // [RULE_12]
        issue && op == mixed_sign_fractional_op |=>
        wr_data == $past(chk_mixed))
        else $error("mixed sign product wrong");

    a_result_next_op: assert property ( // [RULE_13]
        clk_en |=> res_valid == $past(take) &&
        (res_valid || !(wr_byte || wr_pair || wr_prod)))
        else $error("result not written in one cycle");

    a_illegal_refused: assert property ( // [RULE_13]
        issue && op_code > ALM_OP_LAST |=> !res_valid &&
        !(wr_byte || wr_pair || wr_prod) && $stable(flags))
        else $error("illegal opcode was taken");

    // A low enable must hold a pending pulse, not drop it.
    a_freeze_hold: assert property ( // [RULE_13]
        !clk_en |=> $stable(res_valid) && $stable(wr_data) &&
        $stable(flags) && $stable(wr_idx))
        else $error("state moved with clock enable low");

    a_reset_clears: assert property (
        @(posedge ref_clk) disable iff (1'b0)
        rst |=> !res_valid && !(wr_byte || wr_pair || wr_prod) &&
        flags == ALM_FLAGS_RST && wr_data == '0)
        else $error("reset did not clear the outputs");

    a_strobe_single: assert property ( // [RULE_13]
        $onehot0({wr_byte, wr_pair, wr_prod}) &&
        (!(wr_byte || wr_pair || wr_prod) || res_valid))
        else $error("write strobes overlap or stand alone");

    a_prod_carry: assert property ( // [RULE_10]
        issue && op == unsigned_product_op |=>
        flags[FLG_C] == $past(chk_uprod[ALM_WMSB]))
        else $error("product carry wrong");

    c_word_add: cover property (
        issue && op == word_add_immediate_op ##1 flags[FLG_C]);
    c_carry_chain: cover property (
        issue && op == add_carry_op && flags[FLG_C]);
    c_mixed_neg: cover property (
        issue && op == mixed_sign_fractional_op && dst_val[ALM_MSB]);
    c_test_zero: cover property (
        issue && op == zero_minus_test_op ##1 flags[FLG_Z]);
    c_frozen_op: cover property (
        !clk_en && op_valid ##1 issue);

endmodule

// File: tb/alm_regfile.sv
// Register file model standing beside the datapath: reads are combinational,
// writes land on the edge after the datapath raises a write strobe.
// Assumes the bench preloads and inspects registers through poke and peek.
`timescale 1ns/1ps

module alm_regfile
    import alm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic wr_byte,
    input wire logic wr_pair,
    input wire logic wr_prod,
    input wire logic [ALM_RW-1:0] wr_idx,
    input wire logic [ALM_WW-1:0] wr_data,
    input wire logic [ALM_RW-1:0] dst_idx,
    input wire logic [ALM_RW-1:0] src_idx,
    output logic [ALM_DW-1:0] dst_val,
    output logic [ALM_DW-1:0] dst_hi_val,
    output logic [ALM_DW-1:0] src_val
);
    logic [ALM_DW-1:0] regs [0:31];

    assign dst_val = regs[dst_idx];
    assign dst_hi_val = regs[dst_idx + 5'h01];
    assign src_val = regs[src_idx];

    // The write lands one edge late, so a dependent op must wait a cycle.
    always @(posedge ref_clk) begin
        if (wr_byte) begin
            regs[wr_idx] <= wr_data[7:0];
        end
        if (wr_pair) begin
            regs[wr_idx] <= wr_data[7:0];
            regs[wr_idx + 5'h01] <= wr_data[15:8];
        end
        if (wr_prod) begin
            regs[0] <= wr_data[7:0];
            regs[1] <= wr_data[15:8];
        end
    end

    task automatic poke(input logic [4:0] i, input logic [7:0] v);
        regs[i] = v;
    endtask

    function automatic logic [7:0] peek(input logic [4:0] i);
        return regs[i];
    endfunction
endmodule

// File: tb/alm_unit_test.sv
// Self-checking bench for the arithmetic, logic and multiply datapath.
// Assumes a 50 MHz clock and the register file model as the far side.
`timescale 1ns/1ps

module alm_unit_test
    import alm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic op_valid = 1'b0;
    logic [ALM_OPW-1:0] op_code = 5'h00;
    logic [ALM_RW-1:0] dst_idx = 5'h00;
    logic [ALM_RW-1:0] src_idx = 5'h00;
    logic [ALM_DW-1:0] imm_k = 8'h00;
    logic [ALM_DW-1:0] dst_val, dst_hi_val, src_val;
    logic res_valid, wr_byte, wr_pair, wr_prod;
    logic [ALM_RW-1:0] wr_idx;
    logic [ALM_WW-1:0] wr_data;
    logic [ALM_FW-1:0] flags;
    int err_count = 0;
    int check_count = 0;

    always #10 ref_clk = ~ref_clk;

    alm_unit dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .op_valid(op_valid), .op_code(op_code), .dst_idx(dst_idx),
        .dst_val(dst_val), .dst_hi_val(dst_hi_val), .src_val(src_val),
        .imm_k(imm_k), .res_valid(res_valid), .wr_byte(wr_byte),
        .wr_pair(wr_pair), .wr_prod(wr_prod), .wr_idx(wr_idx),
        .wr_data(wr_data), .flags(flags));

    alm_regfile rf (.ref_clk(ref_clk), .wr_byte(wr_byte),
        .wr_pair(wr_pair), .wr_prod(wr_prod), .wr_idx(wr_idx),
        .wr_data(wr_data), .dst_idx(dst_idx), .src_idx(src_idx),
        .dst_val(dst_val), .dst_hi_val(dst_hi_val), .src_val(src_val));

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Issues one op and lets the write-back edge pass before returning.
    task automatic op(input alm_op_e o, input logic [4:0] d, s,
                      input logic [7:0] k);
        op_code = o;
        dst_idx = d;
        src_idx = s;
        imm_k = k;
        op_valid = 1'b1;
        @(negedge ref_clk);
        op_valid = 1'b0;
        chk("res_valid", 16'h0001, {15'h0000, res_valid});
        @(negedge ref_clk);
    endtask

    function automatic logic [15:0] rd(input logic [4:0] i);
        return {8'h00, rf.peek(i)};
    endfunction

    task automatic t_add_carry();
        rf.poke(2, 8'hF0);
        rf.poke(3, 8'h20);
        rf.poke(4, 8'h01);
        op(add_op, 2, 3, 8'h00);
        chk("add flags", 16'h0001, {10'h000, flags});
        op(add_carry_op, 4, 2, 8'h00);
        chk("adc", 16'h0012, rd(4));
    endtask

    task automatic t_word();
        rf.poke(24, 8'hFF);
        rf.poke(25, 8'hFF);
        op(word_add_immediate_op, 24, 0, 8'h01);
        chk("wadd", 16'h0000, {rf.peek(25), rf.peek(24)});
        rf.poke(26, 8'h00);
        rf.poke(27, 8'h00);
        op(word_sub_immediate_op, 26, 0, 8'h3F);
        chk("wsub", 16'hFFC1, {rf.peek(27), rf.peek(26)});
    endtask

    task automatic t_sub_const();
        rf.poke(16, 8'h10);
        rf.poke(17, 8'h10);
        op(sub_constant_op, 16, 0, 8'h11);
        chk("subc", 16'h00FF, rd(16));
        chk("borrow", 16'h0001, {15'h0000, flags[FLG_C]});
        op(sub_constant_carry_op, 17, 0, 8'h05);
        chk("sbcc", 16'h000A, rd(17));
    endtask

    task automatic t_logic();
        rf.poke(18, 8'h81);
        rf.poke(19, 8'h5A);
        op(bit_set_mask_op, 18, 0, 8'h0E);
        chk("bset", 16'h008F, rd(18));
        op(bit_clear_mask_op, 18, 0, 8'h81);
        chk("bclr", 16'h000E, rd(18));
        op(ones_complement_op, 19, 0, 8'h00);
        chk("com", 16'h00A5, rd(19));
    endtask

    task automatic t_test();
        rf.poke(20, 8'h00);
        rf.poke(21, 8'h80);
        op(zero_minus_test_op, 20, 0, 8'h00);
        chk("zero", 16'h0001, 16'({flags[FLG_N], flags[FLG_Z]}));
        op(zero_minus_test_op, 21, 0, 8'h00);
        chk("minus", 16'h0001, 16'({flags[FLG_Z], flags[FLG_N]}));
        chk("kept", 16'h0080, rd(21));
    endtask

    // Operands are chosen so that wrong signedness gives another product.
    task automatic t_mul();
        logic [15:0] e;
        rf.poke(22, 8'hFE);
        rf.poke(23, 8'h83);
        op(unsigned_product_op, 22, 23, 8'h00);
        e = 16'h00FE * 16'h0083;
        chk("mul", e, {rf.peek(1), rf.peek(0)});
        op(fractional_product_op, 22, 23, 8'h00);
        chk("fractional_product_op", e << 1, {rf.peek(1), rf.peek(0)});
        op(mixed_sign_fractional_op, 22, 23, 8'h00);
        e = 16'hFFFE * 16'h0083;
        chk("mixed_sign_fractional_op", e << 1, {rf.peek(1), rf.peek(0)});
    endtask

    // And, or, plain subtracts and the signed products, with flags checked on the subtracts only.
    task automatic t_other_ops();
        rf.poke(5, 8'hC3);
        rf.poke(6, 8'h5A);
        rf.poke(7, 8'h00);
        rf.poke(8, 8'hFE);
        rf.poke(9, 8'h83);
        op(and_op, 5, 6, 8'h00);
        chk("and", 16'h0042, rd(5));
        op(or_op, 5, 6, 8'h00);
        chk("or", 16'h005A, rd(5));
        op(sub_op, 5, 6, 8'h00);
        chk("sub zero", 16'h0002, {10'h000, flags});
        op(sub_op, 7, 6, 8'h00);
        chk("sub flags", 16'h0035, {10'h000, flags});
        op(sub_carry_op, 7, 6, 8'h00);
        chk("sbc", 16'h004B, rd(7));
        chk("sbc flags", 16'h0038, {10'h000, flags});
        op(signed_product_op, 8, 9, 8'h00);
        chk("muls", 16'h00FA, {rf.peek(1), rf.peek(0)});
        op(signed_unsigned_product_op, 8, 9, 8'h00);
        chk("mulsu", 16'hFEFA, {rf.peek(1), rf.peek(0)});
        op(fractional_signed_op, 8, 9, 8'h00);
        chk("fmuls", 16'h01F4, {rf.peek(1), rf.peek(0)});
    endtask

    // Refused work: an illegal code, a low clock enable, a mid-run reset.
    task automatic t_refuse();
        rf.poke(10, 8'h0F);
        rf.poke(11, 8'h01);
        op_code = 5'h14;
        dst_idx = 5'h0A;
        op_valid = 1'b1;
        @(negedge ref_clk);
        chk("illegal", 16'h0000, {15'h0000, res_valid});
        chk("illegal flags", 16'h0038, {10'h000, flags});
        op_code = ones_complement_op;
        clk_en = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("frozen", 16'h0000, {15'h0000, res_valid});
        chk("frozen reg", 16'h000F, rd(10));
        clk_en = 1'b1;
        @(negedge ref_clk);
        op_valid = 1'b0;
        clk_en = 1'b0;
        @(negedge ref_clk);
        chk("held pulse", 16'h0001, {15'h0000, res_valid});
        clk_en = 1'b1;
        @(negedge ref_clk);
        chk("com flags", 16'h0035, {10'h000, flags});
        chk("com reg", 16'h00F0, rd(10));
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        chk("rerun valid", 16'h0000, {15'h0000, res_valid});
        chk("rerun flags", 16'h0000, {10'h000, flags});
        op(add_carry_op, 11, 11, 8'h00);
        chk("adc after reset", 16'h0002, rd(11));
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        chk("reset flags", 16'h0000, {10'h000, flags});
        t_add_carry();
        t_word();
        t_sub_const();
        t_logic();
        t_test();
        t_mul();
        t_other_ops();
        t_refuse();
        summarize();
    end

    // The tests need about 61 cycles; this cuts a hang short.
    initial begin
        #100000;
        err_count++;
        summarize();
    end
endmodule
